// >>> core/pamu_blk_mem.sv
`timescale 1ns/10ps
module pamu_blk_mem (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic [6:0] i_chk_addr,
    output logic [15:0] o_chk_data,
    input wire logic [6:0] i_io_addr,
    output logic [15:0] o_io_data,
    input wire logic i_wr_en,
    input wire logic [6:0] i_wr_addr,
    input wire logic [15:0] i_wr_data
);
    import pamu_pkg::*;

    // Word 0-63 processor map, 64-127 DMA map; one bit per 1k block
    logic [15:0] mem [0:127];

    // Flop-array read is immediate, so the check costs no wait state
    assign o_chk_data = mem[i_chk_addr];
    assign o_io_data = mem[i_io_addr];

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            for (int i = 0; i < 128; i++) begin
                mem[i] <= 16'h0000;
            end
        end else if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
    end

endmodule // pamu_blk_mem

// >>> core/pamu_page_mem.sv
`timescale 1ns/10ps
module pamu_page_mem (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic [8:0] i_rd_addr,
    output logic [15:0] o_rd_data,
    input wire logic i_wr_en,
    input wire logic [8:0] i_wr_addr,
    input wire logic [15:0] i_wr_data
);
    import pamu_pkg::*;

    // Both page sets: index = {set, addr_state_bits, logical_page_index}
    logic [15:0] mem [0:511];

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            // Identity mapping, lock and protect clear
            for (int i = 0; i < 512; i++) begin
                mem[i] <= {8'h00, 8'(i)};
            end
            o_rd_data <= 16'h0000;
        end else begin
            if (i_wr_en) begin
                mem[i_wr_addr] <= i_wr_data;
            end
            // One-cycle read models the lookup that costs a wait state
            o_rd_data <= mem[i_rd_addr];
        end
    end

endmodule // pamu_page_mem

// >>> core/pamu_pkg.sv
package pamu_pkg;

    // Address and page geometry
    localparam int PAGE_W = 16;
    localparam int PPA_W = 8;
    localparam int LOW_W = 12;
    localparam int TAG_W = 9;
    localparam int NCACHE = 3;

    // Page register field layout, bit 0 = least significant
    localparam int PPA_LSB = 0;
    localparam int EW_BIT = 11;
    localparam int LOCK_LSB = 12;
    localparam logic [15:0] PAGE_WMASK = 16'hF8FF;
    localparam logic [3:0] LOCK_OPEN = 4'hF;
    localparam logic [3:0] KEY_MASTER = 4'h0;

    // I/O command map: bit 15 clear = output (write), set = input (read)
    localparam int IO_RD_BIT = 15;
    localparam logic [6:0] IO_IPAGE_HI = 7'h51;
    localparam logic [6:0] IO_OPAGE_HI = 7'h52;
    localparam logic [6:0] IO_BPU_HI = 7'h50;
    localparam logic [14:0] IO_CR0 = 15'h1F50;
    localparam logic [14:0] IO_CR1 = 15'h1F51;

    // Control registers
    localparam logic [15:0] CR0_RST = 16'h00C6;
    localparam logic [15:0] CR1_RST = 16'hC3FF;
    localparam logic [15:0] CR1_RSVD = 16'h03FF;
    localparam int SPD_BIT = 7;
    localparam int CR1_KEEP_LSB = 10;

    // Cache slots and fault bits
    localparam logic [1:0] SLOT_INSTR = 2'h0;
    localparam logic [1:0] SLOT_OPER = 2'h1;
    localparam logic [1:0] SLOT_DMA = 2'h2;
    localparam int FT_CPU = 0;
    localparam int FT_DMA = 1;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOOKUP = 2'b01,
        ST_AWAIT = 2'b10,
        ST_IORD = 2'b11
    } pamu_state_t;

endpackage

// >>> core/pamu_top.sv
`timescale 1ns/10ps
module pamu_top (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_addr_valid,
    input wire logic [pamu_pkg::PAGE_W-1:0] i_muxed_internal_bus,
    input wire logic [3:0] i_addr_state_bits,
    input wire logic i_data_not_instr,
    input wire logic i_dma_acknowledge,
    input wire logic i_write,
    input wire logic [3:0] i_proc_key_bits,
    input wire logic i_io_strobe,
    input wire logic [15:0] i_io_addr,
    input wire logic [15:0] i_io_wdata,
    output logic [pamu_pkg::PPA_W-1:0] o_extended_addr_out,
    output logic [pamu_pkg::LOW_W-1:0] o_phys_addr_low,
    output logic o_addr_phase_ready,
    output logic o_data_phase_ready,
    output logic o_protection_fault,
    output logic [1:0] o_fault_flags,
    output logic [15:0] o_memfault_capture_reg,
    output logic [15:0] o_io_rdata,
    output logic o_io_rvalid
);
    import pamu_pkg::*;

    typedef struct packed {
        pamu_state_t st;
        logic [1:0] cnt;
        logic [NCACHE-1:0] c_vld;
        logic [NCACHE-1:0][TAG_W-1:0] c_tag;
        logic [NCACHE-1:0][15:0] c_ent;
        logic [1:0] sel;
        logic [TAG_W-1:0] tag;
        logic [3:0] key;
        logic wr;
        logic [1:0] blk;
        logic [PPA_W-1:0] ext;
        logic [LOW_W-1:0] low;
        logic pflt;
        logic [1:0] flt;
        logic [15:0] memfault_capture_reg;
        logic [15:0] cr0;
        logic [5:0] cr1;
        logic [15:0] ioa;
        logic [15:0] rdata;
        logic rvalid;
    } pamu_regs_t;

    pamu_regs_t s_r;
    pamu_regs_t s_nxt;

    function automatic logic [1:0] cache_slot(input logic dma, input logic data);
        if (dma) begin
            return SLOT_DMA;
        end
        return data ? SLOT_OPER : SLOT_INSTR;
    endfunction

    function automatic logic prot_fault(input logic [15:0] ent, input logic [3:0] key,
                                        input logic instr, input logic wr,
                                        input logic blk_prot);
        logic [3:0] lock;
        logic key_ok;
        lock = ent[LOCK_LSB +: 4];
        key_ok = (lock == LOCK_OPEN) || (key == KEY_MASTER) || (key == lock);
        return !key_ok
            || (instr && ent[EW_BIT])
            || (!instr && wr && ent[EW_BIT])
            || (wr && blk_prot);
    endfunction

    logic [1:0] req_sel;
    logic [TAG_W-1:0] req_tag;
    logic hit;
    logic take;
    logic in_lookup;
    logic check_now;
    logic [15:0] chk_ent;
    logic [1:0] chk_sel;
    logic [3:0] chk_key;
    logic chk_wr;
    logic [1:0] chk_blk;
    logic [9:0] blk_idx;
    logic [15:0] bp_word;
    logic bp_bit;
    logic fault;
    logic [1:0] wa;
    logic miss_wait_enable;
    logic io_wr;
    logic io_rd;
    logic page_wr;
    logic bpu_wr;
    logic [8:0] pm_raddr;
    logic [15:0] pm_rdata;
    logic [15:0] bp_io_word;
    logic [15:0] io_mux;

    // Operand set is used by DMA whatever the indicator says
    assign req_sel = cache_slot(i_dma_acknowledge, i_data_not_instr);
    assign req_tag = {i_data_not_instr | i_dma_acknowledge, i_addr_state_bits,
                      i_muxed_internal_bus[15:12]};
    assign hit = s_r.c_vld[req_sel] && (s_r.c_tag[req_sel] == req_tag);
    assign take = i_addr_valid && (s_r.st == ST_IDLE);
    assign in_lookup = (s_r.st == ST_LOOKUP);
    assign check_now = (take && hit) || in_lookup;

    assign chk_ent = in_lookup ? pm_rdata : s_r.c_ent[req_sel];
    assign chk_sel = in_lookup ? s_r.sel : req_sel;
    assign chk_key = in_lookup ? s_r.key : i_proc_key_bits;
    assign chk_wr = in_lookup ? s_r.wr : i_write;
    assign chk_blk = in_lookup ? s_r.blk : i_muxed_internal_bus[11:10];

    // First block of the map sits in the word's most significant bit
    assign blk_idx = {chk_ent[PPA_LSB +: PPA_W], chk_blk};
    assign bp_bit = bp_word[4'hF - blk_idx[3:0]];
    assign fault = prot_fault(chk_ent, chk_key, chk_sel == SLOT_INSTR, chk_wr, bp_bit);

    assign wa = s_r.cr1[5:4];
    assign miss_wait_enable = s_r.cr0[SPD_BIT];

    assign io_wr = i_io_strobe && !i_io_addr[IO_RD_BIT];
    assign io_rd = i_io_strobe && i_io_addr[IO_RD_BIT];
    assign page_wr = io_wr && ((i_io_addr[14:8] == IO_IPAGE_HI)
                               || (i_io_addr[14:8] == IO_OPAGE_HI));
    assign bpu_wr = io_wr && (i_io_addr[14:8] == IO_BPU_HI) && !i_io_addr[7];
    // Bit 9 of the command tells instruction set from operand set
    assign pm_raddr = take ? req_tag : {i_io_addr[9], i_io_addr[7:0]};

    pamu_page_mem u_page_mem (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_rd_addr(pm_raddr),
        .o_rd_data(pm_rdata),
        .i_wr_en(page_wr),
        .i_wr_addr({i_io_addr[9], i_io_addr[7:0]}),
        .i_wr_data(i_io_wdata & PAGE_WMASK)
    );

    pamu_blk_mem u_blk_mem (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_chk_addr({chk_sel == SLOT_DMA, blk_idx[9:4]}),
        .o_chk_data(bp_word),
        .i_io_addr(s_r.ioa[6:0]),
        .o_io_data(bp_io_word),
        .i_wr_en(bpu_wr),
        .i_wr_addr(i_io_addr[6:0]),
        .i_wr_data(i_io_wdata)
    );

    always_comb begin
        io_mux = 16'h0000;
        if ((s_r.ioa[14:8] == IO_IPAGE_HI) || (s_r.ioa[14:8] == IO_OPAGE_HI)) begin
            io_mux = pm_rdata;
        end else if ((s_r.ioa[14:8] == IO_BPU_HI) && !s_r.ioa[7]) begin
            io_mux = bp_io_word;
        end else if (s_r.ioa[14:0] == IO_CR0) begin
            io_mux = s_r.cr0;
        end else if (s_r.ioa[14:0] == IO_CR1) begin
            io_mux = {s_r.cr1, CR1_RSVD[9:0]};
        end
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.pflt = 1'b0;
        s_nxt.flt = 2'b00;
        s_nxt.rvalid = 1'b0;
        unique case (s_r.st)
            ST_IDLE: begin
                if (take) begin
                    s_nxt.low = i_muxed_internal_bus[LOW_W-1:0];
                    s_nxt.sel = req_sel;
                    s_nxt.tag = req_tag;
                    s_nxt.key = i_proc_key_bits;
                    s_nxt.wr = i_write;
                    s_nxt.blk = i_muxed_internal_bus[11:10];
                    if (hit) begin
                        s_nxt.ext = chk_ent[PPA_LSB +: PPA_W];
                        s_nxt.cnt = wa;
                        s_nxt.st = (wa != 2'd0) ? ST_AWAIT : ST_IDLE;
                    end else begin
                        s_nxt.st = ST_LOOKUP;
                    end
                end else if (io_rd) begin
                    s_nxt.ioa = i_io_addr;
                    s_nxt.st = ST_IORD;
                end
            end
            ST_LOOKUP: begin
                s_nxt.c_vld[s_r.sel] = 1'b1;
                s_nxt.c_tag[s_r.sel] = s_r.tag;
                s_nxt.c_ent[s_r.sel] = pm_rdata;
                s_nxt.ext = pm_rdata[PPA_LSB +: PPA_W];
                // With the extra wait on, the lookup cycle comes before the programmed ones
                if (miss_wait_enable || (wa == 2'd0)) begin
                    s_nxt.cnt = wa;
                end else begin
                    s_nxt.cnt = wa - 2'd1;
                end
                s_nxt.st = (s_nxt.cnt != 2'd0) ? ST_AWAIT : ST_IDLE;
            end
            ST_AWAIT: begin
                s_nxt.cnt = s_r.cnt - 2'd1;
                s_nxt.st = (s_r.cnt == 2'd1) ? ST_IDLE : ST_AWAIT;
            end
            ST_IORD: begin
                s_nxt.rdata = io_mux;
                s_nxt.rvalid = 1'b1;
                s_nxt.st = ST_IDLE;
            end
        endcase
        if (check_now && fault) begin
            s_nxt.pflt = 1'b1;
            s_nxt.flt[(chk_sel == SLOT_DMA) ? FT_DMA : FT_CPU] = 1'b1;
            s_nxt.memfault_capture_reg = chk_ent;
        end
        if (io_wr && (i_io_addr[14:0] == IO_CR0)) begin
            s_nxt.cr0 = i_io_wdata;
        end
        if (io_wr && (i_io_addr[14:0] == IO_CR1)) begin
            s_nxt.cr1 = i_io_wdata[15:CR1_KEEP_LSB];
        end
        // A rewritten page register may sit in any cache; drop them all
        if (page_wr) begin
            s_nxt.c_vld = '0;
        end
        if (!i_resetn) begin
            s_nxt = '0;
            s_nxt.st = ST_IDLE;
            s_nxt.cr0 = CR0_RST;
            s_nxt.cr1 = CR1_RST[15:CR1_KEEP_LSB];
        end
    end

    always_ff @(posedge i_mclk) begin
        s_r <= s_nxt;
    end

    assign o_extended_addr_out = s_r.ext;
    assign o_phys_addr_low = s_r.low;
    assign o_addr_phase_ready = !((s_r.st == ST_AWAIT)
                                  || (in_lookup && (wa != 2'd0)));
    assign o_data_phase_ready = !(in_lookup && miss_wait_enable && (wa == 2'd0));
    assign o_protection_fault = s_r.pflt;
    assign o_fault_flags = s_r.flt;
    assign o_memfault_capture_reg = s_r.memfault_capture_reg;
    assign o_io_rdata = s_r.rdata;
    assign o_io_rvalid = s_r.rvalid;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    low_pass_a: assert property (take |=> o_phys_addr_low == $past(i_muxed_internal_bus[11:0]))
        else $error("low address bits not passed");
    hit_ext_a: assert property (take && hit |=> o_extended_addr_out == $past(chk_ent[7:0]))
        else $error("hit did not present cached page");
    miss_refill_a: assert property (take && !hit |=> in_lookup ##1
                                    (s_r.c_tag[s_r.sel] == s_r.tag) && s_r.c_vld[s_r.sel])
        else $error("miss did not refill cache");
    miss_dwait_a: assert property (take && !hit && miss_wait_enable && wa == 2'd0 |=>
                                   !o_data_phase_ready ##1 o_data_phase_ready)
        else $error("miss data wait wrong");
    miss_awaits_a: assert property (take && !hit && miss_wait_enable && wa == 2'd2 && !io_wr |=>
                                    !o_addr_phase_ready [*3] ##1 o_addr_phase_ready)
        else $error("miss address wait count wrong");
    hit_awaits_a: assert property (take && hit && wa == 2'd1 && !io_wr |=>
                                   !o_addr_phase_ready ##1 o_addr_phase_ready)
        else $error("programmed wait count wrong");
    master_key_a: assert property (check_now && chk_key == 4'h0 && !chk_ent[EW_BIT] && !bp_bit
                                   |=> !o_protection_fault)
        else $error("master key faulted");
    open_lock_a: assert property (check_now && chk_ent[15:12] == 4'hF && !chk_ent[EW_BIT]
                                  && !bp_bit |=> !o_protection_fault)
        else $error("open lock faulted");
    key_miss_a: assert property (check_now && chk_key != 4'h0 && chk_ent[15:12] != 4'hF
                                 && chk_key != chk_ent[15:12] |=> o_protection_fault)
        else $error("lock mismatch not faulted");
    fault_flag_a: assert property (o_protection_fault |-> $onehot(o_fault_flags)
                                   && o_memfault_capture_reg == $past(chk_ent))
        else $error("fault flag or capture wrong");
    exec_prot_a: assert property (check_now && chk_sel == SLOT_INSTR && chk_ent[EW_BIT]
                                  |=> o_protection_fault && o_fault_flags[FT_CPU])
        else $error("execute protect missed");
    io_read_a: assert property (io_rd && s_r.st == ST_IDLE && !i_addr_valid |=>
                                !o_io_rvalid ##1 o_io_rvalid)
        else $error("io read latency wrong");

    hit_cov: cover property (take && hit);
    miss_cov: cover property (take && !hit ##1 in_lookup);
    fault_cov: cover property (o_protection_fault && o_fault_flags[FT_DMA]);

endmodule // pamu_top

// >>> verification/pamu_cpu_model.sv
`timescale 1ns/10ps
module pamu_cpu_model (
    input wire logic i_mclk,
    input wire logic i_addr_rdy,
    input wire logic i_data_rdy,
    input wire logic i_fault,
    input wire logic [1:0] i_flags,
    input wire logic i_rvalid,
    input wire logic [15:0] i_rdata,
    output logic o_valid,
    output logic [15:0] o_bus,
    output logic [3:0] o_state,
    output logic o_dn,
    output logic o_dma,
    output logic o_wr,
    output logic [3:0] o_key,
    output logic o_ios,
    output logic [15:0] o_ioa,
    output logic [15:0] o_iod
);
    logic hung;
    logic flt;
    logic [1:0] flg;
    logic [15:0] rd;
    int lat;

    initial begin
        {o_valid, o_dn, o_dma, o_wr, o_ios, hung} = '0;
        {o_bus, o_state, o_key, o_ioa, o_iod} = '0;
    end

    // Bit 15 picks the read command, the low byte selects the entry
    function automatic logic [15:0] page_addr(input logic rd_n, input logic op,
                                              input logic [7:0] idx);
        return {rd_n, op ? 7'h52 : 7'h51, idx};
    endfunction

    // Released bus, state, write and key lines carry the inverse so a stale value can never look right; o_dn and o_dma hold
    task automatic mem_cycle(input logic [15:0] a, input logic [3:0] s, input logic d,
                             input logic m, input logic w, input logic [3:0] k);
        @(posedge i_mclk);
        {o_valid, o_bus, o_state, o_dn, o_dma, o_wr, o_key} <= {1'b1, a, s, d, m, w, k};
        @(posedge i_mclk);
        {o_valid, o_bus, o_state, o_wr, o_key} <= {1'b0, ~a, ~s, ~w, ~k};
        {flt, flg, lat, hung} = {1'b0, 2'b00, 32'd0, 1'b1};
        repeat (12) begin
            if (hung) begin
                #1;
                lat++;
                flt = flt | i_fault;
                flg = flg | i_flags;
                if (i_addr_rdy && i_data_rdy) hung = 1'b0;
                else @(posedge i_mclk);
            end
        end
    endtask

    task automatic io_write(input logic [15:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        {o_ios, o_ioa, o_iod} <= {1'b1, a, d};
        @(posedge i_mclk);
        {o_ios, o_ioa, o_iod} <= {1'b0, ~a, ~d};
    endtask

    task automatic io_read(input logic [15:0] a);
        io_write(a, 16'h0000);
        hung = 1'b1;
        repeat (6) begin
            if (hung) begin
                #1;
                if (i_rvalid) {rd, hung} = {i_rdata, 1'b0};
                else @(posedge i_mclk);
            end
        end
    endtask
endmodule // pamu_cpu_model

// >>> verification/pamu_test.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        miscompares++; \
        $display("[ERR] %s expected %0h seen %0h", nm, e, g); \
    end \
end

module pamu_test;
    import pamu_pkg::*;
    logic i_mclk;
    logic i_resetn;
    logic av, dn, dm, wr, ios, ar, dr, flt, rv;
    logic [15:0] bus, ioa, iod, cap, rdat, va, ve;
    logic [3:0] st, key, vs, vk;
    logic [1:0] flg;
    logic [7:0] ext, vi;
    logic [11:0] low;
    logic vd, vm, vw;
    logic [7:0] seq [9];
    int sel;
    int miscompares;
    int tests_run;

    pamu_cpu_model u_cpu (.i_mclk(i_mclk), .i_addr_rdy(ar), .i_data_rdy(dr), .i_fault(flt),
        .i_flags(flg), .i_rvalid(rv), .i_rdata(rdat), .o_valid(av), .o_bus(bus), .o_state(st),
        .o_dn(dn), .o_dma(dm), .o_wr(wr), .o_key(key), .o_ios(ios), .o_ioa(ioa), .o_iod(iod));

    pamu_top u_dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr_valid(av),
        .i_muxed_internal_bus(bus), .i_addr_state_bits(st), .i_data_not_instr(dn),
        .i_dma_acknowledge(dm), .i_write(wr), .i_proc_key_bits(key), .i_io_strobe(ios),
        .i_io_addr(ioa), .i_io_wdata(iod), .o_extended_addr_out(ext), .o_phys_addr_low(low),
        .o_addr_phase_ready(ar), .o_data_phase_ready(dr), .o_protection_fault(flt),
        .o_fault_flags(flg), .o_memfault_capture_reg(cap), .o_io_rdata(rdat), .o_io_rvalid(rv));

    task automatic end_sim();
        $display("Counts: %0d checks, %0d mismatches", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic guard();
        if (u_cpu.hung) begin
            miscompares++;
            end_sim();
        end
    endtask

    task automatic ior(input logic [15:0] a, input logic [15:0] exp, input string nm);
        u_cpu.io_read(a);
        guard();
        `CHK(nm, exp, u_cpu.rd)
    endtask

    function automatic logic exp_flt(input logic [15:0] e, input logic [3:0] k, input logic d,
                                     input logic w);
        logic key_bad;
        key_bad = (k != KEY_MASTER) && (e[15:12] != LOCK_OPEN) && (k != e[15:12]);
        return key_bad || (e[EW_BIT] && (!d || w));
    endfunction

    task automatic access(input logic [15:0] a, input logic [3:0] s, input logic d,
                          input logic m, input logic w, input logic [3:0] k,
                          input logic [15:0] e, input int lat, input logic f);
        u_cpu.mem_cycle(a, s, d, m, w, k);
        guard();
        `CHK("low bits", a[11:0], low)
        `CHK("page", e[7:0], ext)
        `CHK("latency", lat, u_cpu.lat)
        `CHK("fault", f, u_cpu.flt)
        `CHK("flags", f ? {m, !m} : 2'b00, u_cpu.flg)
        if (f) `CHK("capture", e, cap)
    endtask

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    // Catches a hang that slips past the bounded waits
    initial begin
        repeat (100000) @(posedge i_mclk);
        miscompares++;
        end_sim();
    end

    initial begin
        seq = '{8'h32, 8'h31, 8'h3A, 8'h31, 8'h3E, 8'h39, 8'h3D, 8'h52, 8'h32};
        miscompares = 0;
        tests_run = 0;
        i_resetn = 1'b0;
        void'($urandom(32'h9CACDC33));
        repeat (16) @(posedge i_mclk);
        i_resetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            vi = 8'($urandom);
            ior(u_cpu.page_addr(1'b1, i[0], vi), {8'h00, vi}, "page reset");
        end
        ior(16'h9F50, CR0_RST, "cr0 reset");
        ior(16'h9F51, CR1_RST, "cr1 reset");
        ior(16'hD300, 16'h0000, "unmapped");
        $display("test reset done");
        // Default programmed waits: miss pays one lookup wait ahead of them
        va = 16'($urandom);
        vs = 4'($urandom);
        vk = 4'($urandom);
        vd = 1'($urandom);
        ve = {8'h00, vs, va[15:12]};
        access(va, vs, vd, 1'b0, 1'b0, vk, ve, 5, exp_flt(ve, vk, vd, 1'b0));
        access(va ^ 16'h0ABC, vs, vd, 1'b0, 1'b0, vk, ve, 4, exp_flt(ve, vk, vd, 1'b0));
        $display("test wait states done");
        u_cpu.io_write(16'h1F51, 16'h0000);
        ior(16'h9F51, CR1_RSVD, "cr1 zero waits");
        u_cpu.io_write(u_cpu.page_addr(1'b0, 1'b0, 8'h13), 16'h0013);
        for (int i = 0; i < 9; i++) begin
            va = {seq[i][7:4], 12'($urandom)};
            ve = {8'h00, 4'h1, seq[i][7:4]};
            access(va, 4'h1, seq[i][3], seq[i][2], 1'b0, 4'h0, ve,
                   int'(seq[i][1:0]), 1'b0);
        end
        $display("test caches done");
        for (int i = 0; i < 24; i++) begin
            vm = ($urandom % 4) == 0;
            vd = vm | 1'($urandom);
            vs = 4'($urandom);
            va = 16'($urandom);
            ve = 16'($urandom) & PAGE_WMASK;
            if ($urandom % 4 == 0) ve[15:12] = LOCK_OPEN;
            sel = $urandom % 3;
            vk = sel == 0 ? KEY_MASTER : sel == 1 ? ve[15:12] : 4'($urandom);
            vw = vd & 1'($urandom);
            u_cpu.io_write(u_cpu.page_addr(1'b0, vd, {vs, va[15:12]}), ve);
            ior(u_cpu.page_addr(1'b1, vd, {vs, va[15:12]}), ve, "page readback");
            access(va, vs, vd, vm, vw, vk, ve, 2, exp_flt(ve, vk, vd, vw));
        end
        $display("test protection done");
        u_cpu.io_write(u_cpu.page_addr(1'b0, 1'b1, 8'h21), 16'h0021);
        u_cpu.io_write(16'h5048, 16'h0100);
        ior(16'hD048, 16'h0100, "block map");
        access(16'h1C00, 4'h2, 1'b1, 1'b1, 1'b1, 4'h0, 16'h0021, 2, 1'b1);
        access(16'h1800, 4'h2, 1'b1, 1'b1, 1'b1, 4'h0, 16'h0021, 1, 1'b0);
        access(16'h1C00, 4'h2, 1'b1, 1'b0, 1'b1, 4'h0, 16'h0021, 2, 1'b0);
        $display("test block protect done");
        // Two programmed waits with the lookup wait on, then one with it off
        u_cpu.io_write(16'h1F51, 16'h8000);
        u_cpu.io_write(u_cpu.page_addr(1'b0, 1'b1, 8'h22), 16'h0033);
        access(16'h2000, 4'h2, 1'b1, 1'b0, 1'b0, 4'h0, 16'h0033, 4, 1'b0);
        access(16'h2ABC, 4'h2, 1'b1, 1'b0, 1'b0, 4'h0, 16'h0033, 3, 1'b0);
        u_cpu.io_write(16'h1F51, 16'h4000);
        u_cpu.io_write(16'h1F50, 16'h0046);
        ior(16'h9F50, 16'h0046, "cr0 miss wait off");
        u_cpu.io_write(u_cpu.page_addr(1'b0, 1'b1, 8'h22), 16'h0044);
        access(16'h2000, 4'h2, 1'b1, 1'b0, 1'b0, 4'h0, 16'h0044, 2, 1'b0);
        access(16'h2FFF, 4'h2, 1'b1, 1'b0, 1'b0, 4'h0, 16'h0044, 2, 1'b0);
        $display("test wait programming done");
        end_sim();
    end
endmodule // pamu_test
